// [hdl/lmc_pkg.sv]
// shared constants of the logger mission configuration block
package lmc_pkg;
	localparam logic [15:0] LMC_ADDR_LOW_THR = 16'h020B;
	localparam logic [15:0] LMC_ADDR_HIGH_THR = 16'h020C;
	localparam logic [15:0] LMC_ADDR_INTERVAL = 16'h020D;
	localparam logic [15:0] LMC_ADDR_CONTROL = 16'h020E;
	localparam logic [15:0] LMC_ADDR_READOUT = 16'h0211;
	localparam logic [15:0] LMC_ADDR_STATUS = 16'h0214;
	localparam logic [15:0] LMC_ADDR_PAGE_FIRST = 16'h0200;
	localparam logic [15:0] LMC_ADDR_PAGE_LAST = 16'h0213;

	localparam int LMC_CTL_CRYSTAL_STOP = 7;
	localparam int LMC_CTL_CLEAR_ARM = 6;
	localparam int LMC_CTL_MISSION_GATE_N = 4;
	localparam int LMC_CTL_WRAP_LOG_ENABLE = 3;
	localparam int LMC_CTL_LOW_ALARM_SEARCH = 2;
	localparam int LMC_CTL_HIGH_ALARM_SEARCH = 1;
	localparam int LMC_CTL_CLOCK_ALARM_SEARCH = 0;
	localparam logic [7:0] LMC_CTL_WRITE_MASK = 8'hDF;

	localparam int LMC_STS_WIPED = 6;
	localparam int LMC_STS_MISSION = 5;
	localparam int LMC_STS_LOW_HIT = 2;
	localparam int LMC_STS_HIGH_HIT = 1;
	localparam int LMC_STS_CLOCK_ALARM = 0;

	localparam logic [7:0] LMC_CTL_RESET = 8'h00;
	localparam logic [7:0] LMC_THR_RESET = 8'h00;
	localparam logic [7:0] LMC_INTERVAL_RESET = 8'h00;
	localparam logic [7:0] LMC_READ_ZERO = 8'h00;

	localparam logic [7:0] LMC_CODE_UNDER = 8'h00;
	localparam logic [7:0] LMC_CODE_OVER = 8'hFA;
	localparam logic [7:0] LMC_CODE_VALID_MIN = 8'h01;
	localparam logic [7:0] LMC_CODE_VALID_MAX = 8'hF9;
	localparam logic signed [10:0] LMC_CODE_OFFSET = 11'sh050;
	localparam int LMC_HIST_SHIFT = 2;

	localparam int LMC_LOG_ADDR_W = 11;
	localparam logic [10:0] LMC_LOG_LAST = 11'h7FF;
	localparam logic [10:0] LMC_LOG_FIRST = 11'h000;
endpackage : lmc_pkg

// [hdl/lmc_temp_coder.sv]
// converts a signed half-degree reading into the clamped 8-bit code and its histogram bin
module lmc_temp_coder
	import lmc_pkg::*;
(
	input wire logic clk_in, // 100 MHz clock
	input wire logic sys_rst_in, // async reset, active high
	input wire logic conv_valid_in, // one-cycle conversion result strobe
	input wire logic signed [9:0] conv_half_deg_in, // reading in half degrees Celsius
	output logic code_valid_out, // one-cycle strobe with the code
	output logic [7:0] code_out, // clamped temperature code
	output logic [5:0] bin_out // histogram bin of the code
);
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic [5:0] bin;
	} lmc_coder_s;

	lmc_coder_s st_q;
	lmc_coder_s st_d;
	logic signed [10:0] sum;
	logic [7:0] code_c;

	assign sum = 11'(conv_half_deg_in) + LMC_CODE_OFFSET;

	always_comb begin
		st_d = st_q;
		st_d.valid = conv_valid_in;
		code_c = sum[7:0];
		if (sum < $signed({3'b000, LMC_CODE_VALID_MIN})) begin
			code_c = LMC_CODE_UNDER;
		end else if (sum > $signed({3'b000, LMC_CODE_VALID_MAX})) begin
			code_c = LMC_CODE_OVER;
		end
		if (conv_valid_in) begin
			st_d.code = code_c;
			st_d.bin = code_c[7:LMC_HIST_SHIFT];
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign code_valid_out = st_q.valid;
	assign code_out = st_q.code;
	assign bin_out = st_q.bin;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	property p_under_clamp;
		conv_valid_in && (sum < 11'sd1) |=> code_valid_out && code_out == LMC_CODE_UNDER;
	endproperty
	a_under_clamp: assert property (p_under_clamp) else $error("low reading not clamped");

	property p_over_clamp;
		conv_valid_in && (sum > 11'sd249) |=> code_valid_out && code_out == LMC_CODE_OVER;
	endproperty
	a_over_clamp: assert property (p_over_clamp) else $error("high reading not clamped");

	property p_valid_pass;
		conv_valid_in && (sum >= 11'sd1) && (sum <= 11'sd249) |=> code_out == $past(code_c);
	endproperty
	a_valid_pass: assert property (p_valid_pass) else $error("valid code altered");

	property p_bin_edges;
		code_valid_out |-> bin_out == code_out[7:2] && code_out <= LMC_CODE_OVER;
	endproperty
	a_bin_edges: assert property (p_bin_edges) else $error("bin or code range wrong");
endmodule : lmc_temp_coder

// [hdl/lmc_mission_ctrl.sv]
// register page, mission control and alarm search logic of the temperature logger
// Function
// - Each reading is an unsigned 8-bit half-degree code, clamped at FAh.
// - Codes 01h to F9h are genuine readings; extremes mark clamped results.
// - Under-range conversions store 00h, over-range conversions store FAh.
// - Clamped results land in histogram bins 0 and 62.
// - Stored code means code divided by two, minus forty degrees Celsius.
// - Low and high thresholds are full 8-bit registers at 020Bh and 020Ch.
// - Mission conversions are spaced by the sample interval in minutes, 1 to 255.
// - Non-zero interval write starts a mission only if wiped and gate low.
// - Control is read/write; first write in a mission ends it unchanged.
// - Control bit 5 reads zero and cannot be set.
// - Control bit 7 low runs the crystal, high stops it.
// - Clear-arm bit lets only an immediately following clear command wipe mission data.
// - Clear-arm bit drops when the next memory command executes.
// - Control bit 4 low is needed for an interval write to start a mission.
// - Wrap bit high makes a full datalog restart from its first entry.
// - Wrap bit low stops storing into a full log; mission continues.
// - Low search bit answers search after a reading at or below low threshold.
// - High search bit answers search after a reading at or above high threshold.
// - Clock search bit answers search after a clock alarm.
// - Low hit flag sets on readings at or below threshold; cleared by writing zero.
// - Wiped flag drops when an interval write starts a mission.
module lmc_mission_ctrl
	import lmc_pkg::*;
(
	input wire logic clk_in, // 100 MHz clock
	input wire logic sys_rst_in, // async reset, active high
	input wire logic mem_cmd_in, // pulse: a memory function command executes
	input wire logic clear_cmd_in, // with mem_cmd_in: the command is clear memory
	input wire logic reg_wr_in, // pulse: register byte written
	input wire logic reg_rd_in, // pulse: register byte read
	input wire logic [15:0] reg_addr_in, // register address
	input wire logic [7:0] reg_wdata_in, // write data
	input wire logic minute_tick_in, // pulse once per minute from timekeeping
	input wire logic clock_alarm_in, // pulse: clock alarm occurred
	input wire logic conv_valid_in, // pulse: conversion result ready
	input wire logic signed [9:0] conv_half_deg_in, // conversion result in half degrees
	output logic [7:0] reg_rdata_out, // read data
	output logic reg_rvalid_out, // pulse: read data valid
	output logic sample_req_out, // pulse: start a mission conversion
	output logic log_wr_out, // pulse: store code in datalog
	output logic [10:0] log_addr_out, // datalog entry index
	output logic [7:0] log_data_out, // datalog code
	output logic hist_inc_out, // pulse: bump histogram bin
	output logic [5:0] hist_bin_out, // histogram bin index
	output logic mission_clear_out, // pulse: wipe stamps, histogram, counters, delay
	output logic mission_active_out, // level: mission in progress
	output logic search_match_out, // level: answer conditional search
	output logic crystal_run_out // level: timekeeping crystal runs
);
	typedef enum logic [0:0] {
		LMC_IDLE,
		LMC_RUN
	} lmc_mission_e;

	typedef struct packed {
		lmc_mission_e mission;
		logic [7:0] low_thr;
		logic [7:0] high_thr;
		logic [7:0] interval;
		logic [7:0] control;
		logic wiped;
		logic low_hit;
		logic high_hit;
		logic clk_alarm;
		logic [7:0] min_cnt;
		logic [10:0] log_next;
		logic log_full;
		logic [7:0] last_code;
		logic [7:0] rdata;
		logic rvalid;
		logic sample_req;
		logic log_wr;
		logic [10:0] log_addr;
		logic [7:0] log_data;
		logic hist_inc;
		logic [5:0] hist_bin;
		logic clear_pulse;
		logic search_match;
		logic crystal_run;
	} lmc_state_s;

	lmc_state_s st_q;
	lmc_state_s st_d;
	logic code_valid;
	logic [7:0] code;
	logic [5:0] bin;
	logic in_page;
	logic minute_done;
	logic search_now;
	logic start_ok;

	lmc_temp_coder u_coder (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.conv_valid_in(conv_valid_in),
		.conv_half_deg_in(conv_half_deg_in),
		.code_valid_out(code_valid),
		.code_out(code),
		.bin_out(bin)
	);

	function automatic logic addr_is(input logic [15:0] a, input logic [15:0] target);
		addr_is = (a == target);
	endfunction : addr_is

	// writes anywhere in the timekeeping/config span end a running mission
	assign in_page = (reg_addr_in >= LMC_ADDR_PAGE_FIRST) && (reg_addr_in <= LMC_ADDR_PAGE_LAST);
	assign minute_done = ({1'b0, st_q.min_cnt} + 9'h001) >= {1'b0, st_q.interval};
	assign start_ok = st_q.wiped && !st_q.control[LMC_CTL_MISSION_GATE_N]
		&& (st_q.mission == LMC_IDLE);
	assign search_now = (st_q.control[LMC_CTL_LOW_ALARM_SEARCH] && st_q.low_hit)
		|| (st_q.control[LMC_CTL_HIGH_ALARM_SEARCH] && st_q.high_hit)
		|| (st_q.control[LMC_CTL_CLOCK_ALARM_SEARCH] && st_q.clk_alarm);

	always_comb begin
		st_d = st_q;
		st_d.rvalid = 1'b0;
		st_d.sample_req = 1'b0;
		st_d.log_wr = 1'b0;
		st_d.hist_inc = 1'b0;
		st_d.clear_pulse = 1'b0;
		// command handling precedes the write so an arm written now survives to the next command
		if (mem_cmd_in) begin
			st_d.control[LMC_CTL_CLEAR_ARM] = 1'b0;
			if (clear_cmd_in && st_q.control[LMC_CTL_CLEAR_ARM]) begin
				st_d.interval = LMC_INTERVAL_RESET;
				st_d.wiped = 1'b1;
				st_d.clear_pulse = 1'b1;
			end
		end
		if (reg_wr_in) begin
			if ((st_q.mission == LMC_RUN) && in_page) begin
				st_d.mission = LMC_IDLE;
			end else if (addr_is(reg_addr_in, LMC_ADDR_LOW_THR)) begin
				st_d.low_thr = reg_wdata_in;
			end else if (addr_is(reg_addr_in, LMC_ADDR_HIGH_THR)) begin
				st_d.high_thr = reg_wdata_in;
			end else if (addr_is(reg_addr_in, LMC_ADDR_INTERVAL)) begin
				st_d.interval = reg_wdata_in;
				if (reg_wdata_in != 8'h00 && start_ok) begin
					st_d.mission = LMC_RUN;
					st_d.wiped = 1'b0;
					st_d.min_cnt = 8'h00;
					st_d.log_next = LMC_LOG_FIRST;
					st_d.log_full = 1'b0;
				end
			end else if (addr_is(reg_addr_in, LMC_ADDR_CONTROL)) begin
				st_d.control = reg_wdata_in & LMC_CTL_WRITE_MASK;
			end else if (addr_is(reg_addr_in, LMC_ADDR_STATUS)) begin
				// status bits can only be written to zero
				if (!reg_wdata_in[LMC_STS_MISSION]) begin
					st_d.mission = LMC_IDLE;
				end
				if (!reg_wdata_in[LMC_STS_LOW_HIT]) begin
					st_d.low_hit = 1'b0;
				end
				if (!reg_wdata_in[LMC_STS_HIGH_HIT]) begin
					st_d.high_hit = 1'b0;
				end
				if (!reg_wdata_in[LMC_STS_CLOCK_ALARM]) begin
					st_d.clk_alarm = 1'b0;
				end
			end
		end
		if ((st_q.mission == LMC_RUN) && minute_tick_in) begin
			if (minute_done) begin
				st_d.min_cnt = 8'h00;
				st_d.sample_req = 1'b1;
			end else begin
				st_d.min_cnt = st_q.min_cnt + 8'h01;
			end
		end
		if (code_valid) begin
			st_d.last_code = code;
			if (st_q.mission == LMC_RUN) begin
				st_d.hist_inc = 1'b1;
				st_d.hist_bin = bin;
				// set after the status write so a hit in the clearing cycle is kept
				if (code <= st_q.low_thr) begin
					st_d.low_hit = 1'b1;
				end
				if (code >= st_q.high_thr) begin
					st_d.high_hit = 1'b1;
				end
				if (!st_q.log_full || st_q.control[LMC_CTL_WRAP_LOG_ENABLE]) begin
					st_d.log_wr = 1'b1;
					st_d.log_addr = st_q.log_next;
					st_d.log_data = code;
					st_d.log_full = 1'b0;
					if (st_q.log_next == LMC_LOG_LAST) begin
						if (st_q.control[LMC_CTL_WRAP_LOG_ENABLE]) begin
							st_d.log_next = LMC_LOG_FIRST;
						end else begin
							st_d.log_full = 1'b1;
						end
					end else begin
						st_d.log_next = st_q.log_next + 11'h001;
					end
				end
			end
		end
		if (clock_alarm_in) begin
			st_d.clk_alarm = 1'b1;
		end
		if (reg_rd_in) begin
			st_d.rvalid = 1'b1;
			if (addr_is(reg_addr_in, LMC_ADDR_LOW_THR)) begin
				st_d.rdata = st_q.low_thr;
			end else if (addr_is(reg_addr_in, LMC_ADDR_HIGH_THR)) begin
				st_d.rdata = st_q.high_thr;
			end else if (addr_is(reg_addr_in, LMC_ADDR_INTERVAL)) begin
				st_d.rdata = st_q.interval;
			end else if (addr_is(reg_addr_in, LMC_ADDR_CONTROL)) begin
				st_d.rdata = st_q.control;
			end else if (addr_is(reg_addr_in, LMC_ADDR_READOUT)) begin
				st_d.rdata = st_q.last_code;
			end else if (addr_is(reg_addr_in, LMC_ADDR_STATUS)) begin
				st_d.rdata = {1'b0, st_q.wiped, st_q.mission == LMC_RUN, 2'b00,
					st_q.low_hit, st_q.high_hit, st_q.clk_alarm};
			end else begin
				st_d.rdata = LMC_READ_ZERO;
			end
		end
		st_d.search_match = search_now;
		st_d.crystal_run = !st_q.control[LMC_CTL_CRYSTAL_STOP];
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_q <= '0;
			st_q.mission <= LMC_IDLE;
			st_q.control <= LMC_CTL_RESET;
			st_q.low_thr <= LMC_THR_RESET;
			st_q.high_thr <= LMC_THR_RESET;
			st_q.interval <= LMC_INTERVAL_RESET;
			st_q.crystal_run <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata_out = st_q.rdata;
	assign reg_rvalid_out = st_q.rvalid;
	assign sample_req_out = st_q.sample_req;
	assign log_wr_out = st_q.log_wr;
	assign log_addr_out = st_q.log_addr;
	assign log_data_out = st_q.log_data;
	assign hist_inc_out = st_q.hist_inc;
	assign hist_bin_out = st_q.hist_bin;
	assign mission_clear_out = st_q.clear_pulse;
	assign mission_active_out = (st_q.mission == LMC_RUN);
	assign search_match_out = st_q.search_match;
	assign crystal_run_out = st_q.crystal_run;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_interval_start;
		reg_wr_in && addr_is(reg_addr_in, LMC_ADDR_INTERVAL) && reg_wdata_in != 8'h00;
	endsequence

	property p_start;
		s_interval_start ##0 start_ok |=> st_q.mission == LMC_RUN && !st_q.wiped;
	endproperty
	a_start: assert property (p_start) else $error("mission did not start");

	property p_no_start_gate;
		s_interval_start ##0 st_q.control[LMC_CTL_MISSION_GATE_N] && st_q.mission == LMC_IDLE
			|=> st_q.mission == LMC_IDLE;
	endproperty
	a_no_start_gate: assert property (p_no_start_gate) else $error("gate ignored");

	property p_ctl_first_write;
		st_q.mission == LMC_RUN && reg_wr_in && addr_is(reg_addr_in, LMC_ADDR_CONTROL)
			&& !mem_cmd_in |=> st_q.mission == LMC_IDLE && $stable(st_q.control);
	endproperty
	a_ctl_first_write: assert property (p_ctl_first_write) else $error("control altered");

	property p_bit5_zero;
		st_q.control[5] == 1'b0;
	endproperty
	a_bit5_zero: assert property (p_bit5_zero) else $error("control bit 5 set");

	property p_arm_drop;
		mem_cmd_in && !(reg_wr_in && addr_is(reg_addr_in, LMC_ADDR_CONTROL))
			|=> !st_q.control[LMC_CTL_CLEAR_ARM];
	endproperty
	a_arm_drop: assert property (p_arm_drop) else $error("clear arm kept");

	sequence s_armed_clear;
		mem_cmd_in && clear_cmd_in && st_q.control[LMC_CTL_CLEAR_ARM] && !reg_wr_in;
	endsequence

	property p_clear;
		s_armed_clear |=> st_q.wiped && st_q.interval == 8'h00 && mission_clear_out
			##1 !mission_clear_out;
	endproperty
	a_clear: assert property (p_clear) else $error("armed clear failed");

	property p_unarmed_clear;
		mem_cmd_in && !st_q.control[LMC_CTL_CLEAR_ARM] |=> !mission_clear_out;
	endproperty
	a_unarmed_clear: assert property (p_unarmed_clear) else $error("clear without arm");

	property p_sample;
		st_q.mission == LMC_RUN && minute_tick_in && minute_done |=> sample_req_out
			&& st_q.min_cnt == 8'h00;
	endproperty
	a_sample: assert property (p_sample) else $error("sample not requested");

	property p_low_hit;
		code_valid && st_q.mission == LMC_RUN && code <= st_q.low_thr |=> st_q.low_hit;
	endproperty
	a_low_hit: assert property (p_low_hit) else $error("low hit missed");

	property p_search;
		search_match_out == $past(search_now);
	endproperty
	a_search: assert property (p_search) else $error("search answer wrong");

	property p_high_search;
		st_q.control[LMC_CTL_HIGH_ALARM_SEARCH] && st_q.high_hit
			&& !(reg_wr_in || mem_cmd_in) ##1 !(reg_wr_in || mem_cmd_in) |=> search_match_out;
	endproperty
	a_high_search: assert property (p_high_search) else $error("high search silent");

	property p_nowrap;
		code_valid && st_q.mission == LMC_RUN && st_q.log_full
			&& !st_q.control[LMC_CTL_WRAP_LOG_ENABLE] |=> !log_wr_out && hist_inc_out;
	endproperty
	a_nowrap: assert property (p_nowrap) else $error("full log written");

	property p_wrap;
		code_valid && st_q.mission == LMC_RUN && st_q.log_next == LMC_LOG_LAST
			&& st_q.control[LMC_CTL_WRAP_LOG_ENABLE] |=> log_wr_out
			&& log_addr_out == LMC_LOG_LAST && st_q.log_next == LMC_LOG_FIRST;
	endproperty
	a_wrap: assert property (p_wrap) else $error("log did not wrap");

	property p_crystal;
		st_q.control[LMC_CTL_CRYSTAL_STOP] ##1 st_q.control[LMC_CTL_CRYSTAL_STOP]
			|-> !crystal_run_out;
	endproperty
	a_crystal: assert property (p_crystal) else $error("crystal still runs");
endmodule : lmc_mission_ctrl

// [bench/lmc_host_model.sv]
// stand-in for the single-wire bus master that reaches the register page
module lmc_host_model (
	input wire logic clk_in, // bench clock
	output logic mem_cmd_out, // memory function command strobe
	output logic clear_cmd_out, // command is clear memory
	output logic reg_wr_out, // register write strobe
	output logic reg_rd_out, // register read strobe
	output logic [15:0] reg_addr_out, // register address
	output logic [7:0] reg_wdata_out // write data
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle control value keeps the clock alarm search off, it fires during most missions
	localparam logic [7:0] CTL_IDLE = 8'h00;

	initial begin
		{reg_wr_out, reg_rd_out, mem_cmd_out, clear_cmd_out} = 4'h0;
		reg_addr_out = 16'hFFFF;
		reg_wdata_out = 8'hFF;
	end

	// threshold code is twice Celsius plus eighty
	function automatic logic [7:0] thr_code(input int celsius);
		return 8'(2 * celsius + 80);
	endfunction : thr_code

	// one-cycle strobe; released lines show the inverse so stale values never pass
	task automatic xfer(input logic [3:0] kind, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		{reg_wr_out, reg_rd_out, mem_cmd_out, clear_cmd_out} <= kind;
		reg_addr_out <= a;
		reg_wdata_out <= d;
		@(posedge clk_in);
		{reg_wr_out, reg_rd_out, mem_cmd_out, clear_cmd_out} <= 4'h0;
		reg_addr_out <= ~a;
		reg_wdata_out <= ~d;
	endtask : xfer
endmodule : lmc_host_model

// [bench/lmc_mission_ctrl_tb.sv]
// self-checking bench for the logger mission control block
module lmc_mission_ctrl_tb import lmc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_in, sys_rst_in = 1'b1;
	logic mem_cmd, clear_cmd, reg_wr, reg_rd;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata_out, log_data_out;
	logic minute_tick_in = 1'b0, clock_alarm_in = 1'b0, conv_valid_in = 1'b0;
	logic signed [9:0] conv_half_deg_in = 10'sh000;
	logic reg_rvalid_out, sample_req_out, log_wr_out, hist_inc_out, mission_clear_out;
	logic mission_active_out, search_match_out, crystal_run_out;
	logic [10:0] log_addr_out;
	logic [5:0] hist_bin_out;
	int mismatches = 0, compares = 0, n_sample = 0, n_clear = 0, seed = 42351;
	logic [7:0] rdq[$];
	logic [18:0] logq[$];
	logic [5:0] hsq[$];
	logic [10:0] log_idx = 11'h000;
	logic log_full = 1'b0, wrap_en = 1'b0;

	lmc_host_model u_host (.clk_in(clk_in), .mem_cmd_out(mem_cmd), .clear_cmd_out(clear_cmd),
		.reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_addr_out(reg_addr),
		.reg_wdata_out(reg_wdata));

	lmc_mission_ctrl u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .mem_cmd_in(mem_cmd),
		.clear_cmd_in(clear_cmd), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .minute_tick_in(minute_tick_in),
		.clock_alarm_in(clock_alarm_in), .conv_valid_in(conv_valid_in),
		.conv_half_deg_in(conv_half_deg_in), .reg_rdata_out(reg_rdata_out),
		.reg_rvalid_out(reg_rvalid_out), .sample_req_out(sample_req_out),
		.log_wr_out(log_wr_out), .log_addr_out(log_addr_out), .log_data_out(log_data_out),
		.hist_inc_out(hist_inc_out), .hist_bin_out(hist_bin_out),
		.mission_clear_out(mission_clear_out), .mission_active_out(mission_active_out),
		.search_match_out(search_match_out), .crystal_run_out(crystal_run_out));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	// sampled mid-cycle so registered outputs have settled
	always @(negedge clk_in) begin
		if (reg_rvalid_out === 1'b1)
			check(reg_rdata_out, rdq.size() ? rdq.pop_front() : 8'hXX);
		if (log_wr_out === 1'b1)
			check({log_addr_out, log_data_out}, logq.size() ? logq.pop_front() : 19'hX);
		if (hist_inc_out === 1'b1)
			check(hist_bin_out, hsq.size() ? hsq.pop_front() : 6'hX);
		if (sample_req_out === 1'b1)
			n_sample++;
		if (mission_clear_out === 1'b1)
			n_clear++;
	end

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		u_host.xfer(4'h8, a, d);
	endtask : wr

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		rdq.push_back(e);
		u_host.xfer(4'h4, a, 8'h00);
	endtask : rd_chk

	task automatic cmd(input logic clr);
		u_host.xfer({3'b001, clr}, 16'h0000, 8'h00);
	endtask : cmd

	task automatic tick;
		@(posedge clk_in);
		minute_tick_in <= 1'b1;
		@(posedge clk_in);
		minute_tick_in <= 1'b0;
	endtask : tick

	task automatic alarm;
		@(posedge clk_in);
		clock_alarm_in <= 1'b1;
		@(posedge clk_in);
		clock_alarm_in <= 1'b0;
	endtask : alarm

	// expected code clamps at both ends; a full log without wrap stores nothing more
	task automatic conv(input logic signed [9:0] raw);
		int v;
		logic [7:0] code;
		v = raw + 80;
		code = (v < 1) ? LMC_CODE_UNDER : (v > 249) ? LMC_CODE_OVER : 8'(v);
		hsq.push_back(code[7:2]);
		if (!log_full)
			logq.push_back({log_idx, code});
		log_full = log_full | (log_idx == 11'h7FF && !wrap_en);
		if (!log_full)
			log_idx = log_idx + 11'h001;
		@(posedge clk_in);
		conv_valid_in <= 1'b1;
		conv_half_deg_in <= raw;
		@(posedge clk_in);
		conv_valid_in <= 1'b0;
		conv_half_deg_in <= ~raw;
	endtask : conv

	task automatic start(input logic [7:0] ctl, input logic [7:0] ivl);
		wr(LMC_ADDR_CONTROL, ctl | 8'h40);
		cmd(1'b1);
		rd_chk(LMC_ADDR_INTERVAL, 8'h00);
		wr(LMC_ADDR_INTERVAL, ivl);
		log_idx = 11'h000;
		log_full = 1'b0;
		wrap_en = ctl[3];
		@(negedge clk_in);
	endtask : start

	task automatic settle;
		repeat (4) @(negedge clk_in);
	endtask : settle

	initial begin
		logic [7:0] d;
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(negedge clk_in);
		check(crystal_run_out, 1'b1);
		for (int a = 16'h020B; a <= 16'h0215; a++) begin
			if (a != 16'h0211)
				rd_chk(16'(a), 8'h00);
		end
		for (int i = 0; i < 2; i++) begin
			d = (i == 0) ? 8'($random(seed)) : 8'hFF;
			wr(LMC_ADDR_LOW_THR, d);
			wr(LMC_ADDR_HIGH_THR, ~d);
			wr(LMC_ADDR_CONTROL, d);
			rd_chk(LMC_ADDR_LOW_THR, d);
			rd_chk(LMC_ADDR_HIGH_THR, ~d);
			rd_chk(LMC_ADDR_CONTROL, d & 8'hDF);
			@(negedge clk_in);
			check(crystal_run_out, !d[7]);
		end
		wr(LMC_ADDR_CONTROL, u_host.CTL_IDLE);
		wr(LMC_ADDR_INTERVAL, 8'h05);
		@(negedge clk_in);
		check(mission_active_out, 1'b0);
		rd_chk(LMC_ADDR_INTERVAL, 8'h05);
		cmd(1'b1);
		rd_chk(LMC_ADDR_STATUS, 8'h00);
		wr(LMC_ADDR_CONTROL, 8'h40);
		cmd(1'b0);
		rd_chk(LMC_ADDR_CONTROL, 8'h00);
		check(n_clear, 0);
		start(8'h10, 8'h03);
		check(n_clear, 1);
		check(mission_active_out, 1'b0);
		rd_chk(LMC_ADDR_STATUS, 8'h40);
		wr(LMC_ADDR_LOW_THR, u_host.thr_code(-32));
		wr(LMC_ADDR_HIGH_THR, u_host.thr_code(80));
		wr(LMC_ADDR_CONTROL, 8'h07);
		wr(LMC_ADDR_INTERVAL, 8'h02);
		@(negedge clk_in);
		check(mission_active_out, 1'b1);
		rd_chk(LMC_ADDR_STATUS, 8'h20);
		tick();
		settle();
		check(n_sample, 0);
		tick();
		settle();
		check(n_sample, 1);
		conv(10'sd46);
		settle();
		rd_chk(LMC_ADDR_READOUT, 8'h7E);
		@(negedge clk_in);
		check(search_match_out, 1'b0);
		conv(-10'sd100);
		settle();
		check(search_match_out, 1'b1);
		wr(LMC_ADDR_STATUS, 8'hFB);
		settle();
		check(search_match_out, 1'b0);
		conv(10'sd200);
		settle();
		check(search_match_out, 1'b1);
		wr(LMC_ADDR_STATUS, 8'hFD);
		settle();
		check(search_match_out, 1'b0);
		alarm();
		settle();
		check(search_match_out, 1'b1);
		wr(LMC_ADDR_STATUS, 8'hFE);
		settle();
		check(search_match_out, 1'b0);
		for (int i = 0; i < 2048; i++)
			conv(10'($random(seed) % 100));
		settle();
		check(logq.size(), 0);
		check(hsq.size(), 0);
		check(mission_active_out, 1'b1);
		wr(LMC_ADDR_CONTROL, 8'h0F);
		@(negedge clk_in);
		check(mission_active_out, 1'b0);
		rd_chk(LMC_ADDR_CONTROL, 8'h07);
		wr(LMC_ADDR_CONTROL, 8'h0F);
		rd_chk(LMC_ADDR_CONTROL, 8'h0F);
		start(8'h08, 8'h01);
		check(mission_active_out, 1'b1);
		for (int i = 0; i < 2049; i++)
			conv(10'($random(seed) % 120));
		settle();
		check(logq.size(), 0);
		check(rdq.size(), 0);
		summarize();
	end

	// whole run needs about 8400 cycles
	initial begin
		repeat (30000) @(posedge clk_in);
		mismatches++;
		summarize();
	end
endmodule : lmc_mission_ctrl_tb
